// ==== hw/bsbse_pkg.sv ====
// Purpose: Shared constants and types of the branch, skip, bit and shift
//          execution unit.
// Assumes: Flag byte layout as named below.
// Notes:   Cycle counts are in core clock cycles.
package bsbse_pkg;

  // ----------------------------------------------------------------
  // Status flag bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // Byte layout
  // ----------------------------------------------------------------
  localparam int BYTE_MSB = 7;
  localparam int BYTE_LSB = 0;
  localparam int NIB_MSB = 3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BIT_ONE = 8'h01;

  // Flags that each group may write back
  localparam logic [7:0] MASK_CMP = 8'h2f;
  localparam logic [7:0] MASK_SHIFT = 8'h0f;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // ----------------------------------------------------------------
  // Cycle counts and program counter steps
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam int PC_STEP = 1;
  localparam int SKIP_SHORT = 2;
  localparam int SKIP_LONG = 3;

  // ----------------------------------------------------------------
  // Operations handed over by the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_IF_REG_BIT_CLEAR,
    OP_SKIP_IF_REG_BIT_SET,
    OP_SKIP_IF_IO_BIT_CLEAR,
    OP_SKIP_IF_IO_BIT_SET,
    OP_BRANCH_IF_FLAG_SET,
    OP_BRANCH_IF_FLAG_CLEAR,
    OP_BRANCH_IF_ZERO,
    OP_BRANCH_IF_NONZERO,
    OP_BRANCH_IF_CARRY,
    OP_BRANCH_IF_NO_CARRY,
    OP_BRANCH_IF_UNSIGNED_GE,
    OP_BRANCH_IF_UNSIGNED_LT,
    OP_BRANCH_IF_NEGATIVE,
    OP_BRANCH_IF_POSITIVE,
    OP_BRANCH_IF_SIGNED_GE,
    OP_BRANCH_IF_SIGNED_LT,
    OP_BRANCH_IF_HALF_CARRY,
    OP_BRANCH_IF_NO_HALF_CARRY,
    OP_BRANCH_IF_TBIT_SET,
    OP_BRANCH_IF_TBIT_CLEAR,
    OP_BRANCH_IF_OVERFLOW,
    OP_BRANCH_IF_NO_OVERFLOW,
    OP_BRANCH_IF_IRQ_ENABLED,
    OP_BRANCH_IF_IRQ_DISABLED,
    OP_SET_IO_BIT,
    OP_CLEAR_IO_BIT,
    OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY
  } bsbse_op_t;

  typedef enum logic [2:0] {
    ALU_CMP,
    ALU_SHL,
    ALU_SHR,
    ALU_ROL,
    ALU_ROR
  } bsbse_alu_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_WAIT
  } bsbse_state_t;

endpackage

// ==== hw/bsbse_alu_if.sv ====
// Purpose: Carries operands and results between the sequencer and the ALU.
// Assumes: Combinational, within one cycle.
// Notes:   Raw flags; the sequencer applies the mask.
`timescale 1ns/1ps
interface bsbse_alu_if;
  import bsbse_pkg::*;
  bsbse_alu_op_t op;
  logic [7:0] operand;
  logic [7:0] imm;
  logic carryIn;
  logic [7:0] result;
  logic flagC;
  logic flagZ;
  logic flagN;
  logic flagV;
  logic flagH;

  modport alu (
    input op, operand, imm, carryIn,
    output result, flagC, flagZ, flagN, flagV, flagH
  );
  modport core (
    output op, operand, imm, carryIn,
    input result, flagC, flagZ, flagN, flagV, flagH
  );
endinterface

// ==== hw/bsbse_alu.sv ====
// Purpose: Compare and shift datapath with its flag results.
// Assumes: Operands stable within the cycle.
// Notes:   Combinational; the sequencer registers results.
`timescale 1ns/1ps
module bsbse_alu (
  // Operand and result bundle
  bsbse_alu_if.alu bus
);
  import bsbse_pkg::*;

  // ----------------------------------------------------------------
  // Compare subtraction, borrow in the top bit
  // ----------------------------------------------------------------
  logic [8:0] diff;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] r;

  assign a = bus.operand;
  assign b = bus.imm;
  assign diff = {1'b0, a} - {1'b0, b};

  // Result and carry per operation
  always_comb begin
    r = BYTE_ZERO;
    bus.flagC = 1'b0;
    unique case (bus.op)
      ALU_CMP: begin
        r = diff[7:0];
        bus.flagC = diff[8];
      end
      ALU_SHL: begin
        r = {a[BYTE_MSB-1:BYTE_LSB], 1'b0};
        bus.flagC = a[BYTE_MSB];
      end
      ALU_SHR: begin
        r = {1'b0, a[BYTE_MSB:BYTE_LSB+1]};
        bus.flagC = a[BYTE_LSB];
      end
      ALU_ROL: begin
        r = {a[BYTE_MSB-1:BYTE_LSB], bus.carryIn};
        bus.flagC = a[BYTE_MSB];
      end
      ALU_ROR: begin
        r = {bus.carryIn, a[BYTE_MSB:BYTE_LSB+1]};
        bus.flagC = a[BYTE_LSB];
      end
    endcase
  end

  // Remaining flags; shifts report overflow as N xor C
  assign bus.result = r;
  assign bus.flagZ = (r == BYTE_ZERO);
  assign bus.flagN = r[BYTE_MSB];
  assign bus.flagV = (bus.op == ALU_CMP) ?
    ((a[BYTE_MSB] & ~b[BYTE_MSB] & ~r[BYTE_MSB]) |
     (~a[BYTE_MSB] & b[BYTE_MSB] & r[BYTE_MSB])) :
    (r[BYTE_MSB] ^ bus.flagC);
  // Half borrow out of the low nibble, compare only
  assign bus.flagH = (~a[NIB_MSB] & b[NIB_MSB]) |
    (b[NIB_MSB] & r[NIB_MSB]) | (r[NIB_MSB] & ~a[NIB_MSB]);
endmodule

// ==== hw/bsbse_exec.sv ====
// Purpose: Executes compare-immediate, skips, flag branches, I/O bit
//          set/clear and shifts for an 8-bit core.
// Assumes: Decoder presents one operation with operands; register,
//          I/O and flag data are on the same clock.
// Notes:   One operation in flight; issueReady drops while a multi-cycle operation runs.
//
// Behaviour
// - Compare immediate subtracts K, no store, sets Z N V C H, 1 cycle.
// - Register bit clear skips next op, no flags, 1-3 cycles.
// - Register bit set skips next op, no flags, 1-3 cycles.
// - I/O bit clear skips next op, no flags, 1-3 cycles.
// - I/O bit set skips next op, no flags, 1-3 cycles.
// - Flag s set branches to PC plus k plus 1, 1 or 2 cycles.
// - Flag s clear branches to PC plus k plus 1, 1 or 2 cycles.
// - Zero branches follow Z set or clear, 1 or 2 cycles.
// - Carry set and unsigned lower branch when C is 1.
// - Carry clear and unsigned same-or-higher branch when C is 0.
// - Negative branch on N set, positive on N clear.
// - Signed greater-or-equal when N xor V is 0, less-than when 1.
// - Half-carry branches follow H set or clear.
// - T branches follow T set or clear.
// - Overflow branches follow V set or clear.
// - Interrupt branches follow I set or clear.
// - Set I/O bit writes 1 to bit b only, no flags, 2 cycles.
// - Clear I/O bit writes 0 to bit b only, no flags, 2 cycles.
// - Left shift moves bits up, zero into bit 0, Z C N V, 1 cycle.
// - Right shift moves bits down, zero into bit 7, Z C N V, 1 cycle.
// - Rotate left takes carry into bit 0, bit 7 out to carry.
// - Rotate right takes carry into bit 7, bit 0 out to carry.
`timescale 1ns/1ps
module bsbse_exec #(
  parameter int PC_W = 16,
  parameter int OFS_W = 7,
  parameter int IO_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Operation issue from the decoder
  input wire logic issueValid,
  output logic issueReady,
  input wire bsbse_pkg::bsbse_op_t issueOp,
  input wire logic [PC_W-1:0] issuePc,
  input wire logic [7:0] issueRegData,
  input wire logic [7:0] issueImm,
  input wire logic [2:0] issueBit,
  input wire logic [2:0] issueFlagSel,
  input wire logic [OFS_W-1:0] issueOffset,
  input wire logic [IO_W-1:0] issueIoAddr,
  input wire logic issueNextTwoWord,
  // Status flags from the core
  input wire logic [7:0] flagsIn,
  // Completion and write-back
  output logic done,
  output logic [PC_W-1:0] pcNext,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic [7:0] flagsOut,
  output logic [7:0] flagsWrMask,
  // I/O space access
  output logic [IO_W-1:0] ioRdAddr,
  input wire logic [7:0] ioRdData,
  output logic ioWrEn,
  output logic [IO_W-1:0] ioWrAddr,
  output logic [7:0] ioWrData
);
  import bsbse_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Bit select shared by register, I/O and flag tests
  function automatic logic bitOf(input logic [7:0] val,
                                 input logic [2:0] idx);
    bitOf = val[idx];
  endfunction

  // Replace one bit of a byte, others untouched
  function automatic logic [7:0] writeBit(input logic [7:0] val,
                                          input logic [2:0] idx,
                                          input logic setIt);
    logic [7:0] m;
    m = BIT_ONE << idx;
    writeBit = setIt ? (val | m) : (val & ~m);
  endfunction

  // Branch condition per operation
  function automatic logic branchCond(input bsbse_op_t op,
                                      input logic [2:0] sel,
                                      input logic [7:0] f);
    branchCond = 1'b0;
    unique case (op)
      OP_BRANCH_IF_FLAG_SET: branchCond = bitOf(f, sel);
      OP_BRANCH_IF_FLAG_CLEAR: branchCond = ~bitOf(f, sel);
      OP_BRANCH_IF_ZERO: branchCond = f[FLAG_Z];
      OP_BRANCH_IF_NONZERO: branchCond = ~f[FLAG_Z];
      OP_BRANCH_IF_CARRY,
      OP_BRANCH_IF_UNSIGNED_LT: branchCond = f[FLAG_C];
      OP_BRANCH_IF_NO_CARRY,
      OP_BRANCH_IF_UNSIGNED_GE: branchCond = ~f[FLAG_C];
      OP_BRANCH_IF_NEGATIVE: branchCond = f[FLAG_N];
      OP_BRANCH_IF_POSITIVE: branchCond = ~f[FLAG_N];
      OP_BRANCH_IF_SIGNED_GE:
        branchCond = ~(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_IF_SIGNED_LT:
        branchCond = f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_IF_HALF_CARRY: branchCond = f[FLAG_H];
      OP_BRANCH_IF_NO_HALF_CARRY: branchCond = ~f[FLAG_H];
      OP_BRANCH_IF_TBIT_SET: branchCond = f[FLAG_T];
      OP_BRANCH_IF_TBIT_CLEAR: branchCond = ~f[FLAG_T];
      OP_BRANCH_IF_OVERFLOW: branchCond = f[FLAG_V];
      OP_BRANCH_IF_NO_OVERFLOW: branchCond = ~f[FLAG_V];
      OP_BRANCH_IF_IRQ_ENABLED: branchCond = f[FLAG_I];
      OP_BRANCH_IF_IRQ_DISABLED: branchCond = ~f[FLAG_I];
      default: branchCond = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_n;

  // Two stages so release never lands near a clock edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  bsbse_state_t state_r;
  bsbse_state_t state_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;
  logic [PC_W-1:0] pcNext_r;
  logic [PC_W-1:0] pcNext_nxt;
  logic regWrEn_r;
  logic [7:0] regWrData_r;
  logic [7:0] flagsOut_r;
  logic [7:0] flagsWrMask_r;
  logic [7:0] flagsWrMask_nxt;
  logic [IO_W-1:0] ioAddr_r;
  logic [2:0] ioBit_r;
  logic ioSet_r;
  logic pendIo_r;
  logic ioWrEn_r;
  logic ioWrEn_nxt;
  logic [7:0] ioWrData_r;
  logic [7:0] ioWrData_nxt;

  // ----------------------------------------------------------------
  // Decode of the issued operation
  // ----------------------------------------------------------------
  logic issueFire;
  logic isCmp;
  logic isShift;
  logic isSkipReg;
  logic isSkipIo;
  logic isSkipSet;
  logic isIoBit;
  logic isBranch;
  logic testBit;
  logic skipTaken;
  logic brTaken;
  logic [1:0] cycNeed;
  logic finishWait;

  assign issueReady = (state_r == ST_IDLE);
  assign issueFire = issueValid & issueReady;
  assign isCmp = (issueOp == OP_COMPARE_IMMEDIATE);
  assign isShift = (issueOp == OP_SHIFT_LEFT_LOGICAL) ||
    (issueOp == OP_SHIFT_RIGHT_LOGICAL) ||
    (issueOp == OP_ROTATE_LEFT_CARRY) ||
    (issueOp == OP_ROTATE_RIGHT_CARRY);
  assign isSkipReg = (issueOp == OP_SKIP_IF_REG_BIT_CLEAR) ||
    (issueOp == OP_SKIP_IF_REG_BIT_SET);
  assign isSkipIo = (issueOp == OP_SKIP_IF_IO_BIT_CLEAR) ||
    (issueOp == OP_SKIP_IF_IO_BIT_SET);
  assign isSkipSet = (issueOp == OP_SKIP_IF_REG_BIT_SET) ||
    (issueOp == OP_SKIP_IF_IO_BIT_SET);
  assign isIoBit = (issueOp == OP_SET_IO_BIT) ||
    (issueOp == OP_CLEAR_IO_BIT);
  assign isBranch = (issueOp >= OP_BRANCH_IF_FLAG_SET) &&
    (issueOp <= OP_BRANCH_IF_IRQ_DISABLED);

  // Skip tests: the I/O byte is read the same cycle the skip is issued
  assign testBit = isSkipIo ? bitOf(ioRdData, issueBit) :
    bitOf(issueRegData, issueBit);
  assign skipTaken = (isSkipReg | isSkipIo) &
    (isSkipSet ? testBit : ~testBit);
  assign brTaken = isBranch & branchCond(issueOp, issueFlagSel, flagsIn);

  // Cycles: skipping a two-word instruction costs one more cycle
  assign cycNeed = skipTaken ? (issueNextTwoWord ? CYC_THREE : CYC_TWO) :
    (brTaken | isIoBit) ? CYC_TWO : CYC_ONE;

  // ----------------------------------------------------------------
  // Program counter targets
  // ----------------------------------------------------------------
  logic [PC_W-1:0] offsetExt;
  logic [PC_W-1:0] pcSeq;
  logic [PC_W-1:0] pcSkip;
  logic [PC_W-1:0] pcBranch;

  // Sign extension lets a branch reach backwards as well
  assign offsetExt = {{(PC_W-OFS_W){issueOffset[OFS_W-1]}},
    issueOffset};
  assign pcSeq = issuePc + PC_W'(PC_STEP);
  assign pcSkip = issuePc + (issueNextTwoWord ? PC_W'(SKIP_LONG) :
    PC_W'(SKIP_SHORT));
  assign pcBranch = issuePc + offsetExt + PC_W'(PC_STEP);
  assign pcNext_nxt = !issueFire ? pcNext_r :
    skipTaken ? pcSkip : brTaken ? pcBranch : pcSeq;

  // ----------------------------------------------------------------
  // Compare and shift datapath
  // ----------------------------------------------------------------
  bsbse_alu_if aluBus();
  logic [7:0] flagsNew;

  assign aluBus.op = isCmp ? ALU_CMP :
    (issueOp == OP_SHIFT_LEFT_LOGICAL) ? ALU_SHL :
    (issueOp == OP_SHIFT_RIGHT_LOGICAL) ? ALU_SHR :
    (issueOp == OP_ROTATE_LEFT_CARRY) ? ALU_ROL : ALU_ROR;
  assign aluBus.operand = issueRegData;
  assign aluBus.imm = issueImm;
  assign aluBus.carryIn = flagsIn[FLAG_C];

  bsbse_alu uAlu (
    .bus(aluBus.alu)
  );

  // Flag byte; H is passed through unless compare writes it
  always_comb begin
    flagsNew = flagsIn;
    flagsNew[FLAG_C] = aluBus.flagC;
    flagsNew[FLAG_Z] = aluBus.flagZ;
    flagsNew[FLAG_N] = aluBus.flagN;
    flagsNew[FLAG_V] = aluBus.flagV;
    flagsNew[FLAG_H] = isCmp ? aluBus.flagH : flagsIn[FLAG_H];
  end

  // Branches, skips and I/O bit ops leave every flag alone
  assign flagsWrMask_nxt = !issueFire ? MASK_NONE :
    isCmp ? MASK_CMP :
    isShift ? MASK_SHIFT : MASK_NONE;

  // ----------------------------------------------------------------
  // Sequencing of multi-cycle operations
  // ----------------------------------------------------------------
  assign finishWait = (state_r == ST_WAIT) && (cnt_r == CYC_ONE);
  assign state_nxt = (issueFire && cycNeed != CYC_ONE) ? ST_WAIT :
    finishWait ? ST_IDLE : state_r;
  assign cnt_nxt = issueFire ? cycNeed - CYC_ONE :
    (state_r == ST_WAIT) ? cnt_r - CYC_ONE : cnt_r;
  assign done_nxt = (issueFire && cycNeed == CYC_ONE) || finishWait;

  // I/O bit write: read in cycle two, written with done
  assign ioRdAddr = (state_r == ST_WAIT) ? ioAddr_r : issueIoAddr;
  assign ioWrEn_nxt = finishWait & pendIo_r;
  assign ioWrData_nxt = ioWrEn_nxt ?
    writeBit(ioRdData, ioBit_r, ioSet_r) : ioWrData_r;

  // State and counters
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r <= ST_IDLE;
      cnt_r <= CYC_ONE;
      done_r <= 1'b0;
      pcNext_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      pcNext_r <= pcNext_nxt;
    end
  end

  // Register and flag write-back, a pulse with done
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regWrEn_r <= 1'b0;
      regWrData_r <= BYTE_ZERO;
      flagsOut_r <= BYTE_ZERO;
      flagsWrMask_r <= MASK_NONE;
    end else begin
      regWrEn_r <= issueFire & isShift;
      regWrData_r <= issueFire ? aluBus.result : regWrData_r;
      flagsOut_r <= issueFire ? flagsNew : flagsOut_r;
      flagsWrMask_r <= flagsWrMask_nxt;
    end
  end

  // I/O bit operation capture and write
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ioAddr_r <= '0;
      ioBit_r <= '0;
      ioSet_r <= 1'b0;
      pendIo_r <= 1'b0;
      ioWrEn_r <= 1'b0;
      ioWrData_r <= BYTE_ZERO;
    end else begin
      ioAddr_r <= issueFire ? issueIoAddr : ioAddr_r;
      ioBit_r <= issueFire ? issueBit : ioBit_r;
      ioSet_r <= issueFire ? (issueOp == OP_SET_IO_BIT) : ioSet_r;
      pendIo_r <= issueFire ? isIoBit : pendIo_r;
      ioWrEn_r <= ioWrEn_nxt;
      ioWrData_r <= ioWrData_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign done = done_r;
  assign pcNext = pcNext_r;
  assign regWrEn = regWrEn_r;
  assign regWrData = regWrData_r;
  assign flagsOut = flagsOut_r;
  assign flagsWrMask = flagsWrMask_r;
  assign ioWrEn = ioWrEn_r;
  assign ioWrAddr = ioAddr_r;
  assign ioWrData = ioWrData_r;
endmodule

// ==== verif/bsbse_exec_props.sv ====
// Purpose: Port timing and result checks.
// Assumes: One operation in flight.
// Notes:   Bound into the unit.
`timescale 1ns/1ps
module bsbse_exec_props #(
  parameter int PC_W = 16,
  parameter int IO_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Issue side
  input wire logic issueValid,
  input wire logic issueReady,
  input wire bsbse_pkg::bsbse_op_t issueOp,
  input wire logic [PC_W-1:0] issuePc,
  input wire logic [7:0] issueRegData,
  input wire logic [IO_W-1:0] issueIoAddr,
  input wire logic [7:0] flagsIn,
  // Results
  input wire logic done,
  input wire logic [PC_W-1:0] pcNext,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] flagsOut,
  input wire logic [7:0] flagsWrMask,
  input wire logic ioWrEn,
  input wire logic [IO_W-1:0] ioWrAddr
);
  import bsbse_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // --------------------
  // Accepted issues
  // --------------------
  wire logic take = issueValid && issueReady;
  wire logic tCmp = take && issueOp == OP_COMPARE_IMMEDIATE;
  wire logic tShf = take && issueOp inside
    {[OP_SHIFT_LEFT_LOGICAL:OP_ROTATE_RIGHT_CARRY]};
  wire logic tBr = take && issueOp inside
    {[OP_BRANCH_IF_FLAG_SET:OP_BRANCH_IF_IRQ_DISABLED]};
  wire logic tSkp = take && issueOp inside
    {[OP_SKIP_IF_REG_BIT_CLEAR:OP_SKIP_IF_IO_BIT_SET]};
  wire logic tIo = take && issueOp inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT};

  // --------------------
  // Properties
  // --------------------
  cmp_result_a:
    assert property (tCmp |=> done && flagsWrMask == MASK_CMP && !regWrEn
      && pcNext == $past(issuePc) + 1'b1) else $error("compare result");
  shift_mask_a:
    assert property (tShf |=> done && regWrEn && flagsWrMask == MASK_SHIFT)
    else $error("shift write-back");
  shl_data_a:
    assert property (take && issueOp == OP_SHIFT_LEFT_LOGICAL |=>
      regWrData == {$past(issueRegData[6:0]), 1'b0}
      && flagsOut[FLAG_C] == $past(issueRegData[7])) else $error("shl");
  shr_data_a:
    assert property (take && issueOp == OP_SHIFT_RIGHT_LOGICAL |=>
      regWrData == {1'b0, $past(issueRegData[7:1])}
      && flagsOut[FLAG_C] == $past(issueRegData[0])) else $error("shr");
  rol_data_a:
    assert property (take && issueOp == OP_ROTATE_LEFT_CARRY |=>
      regWrData == {$past(issueRegData[6:0]), $past(flagsIn[FLAG_C])})
    else $error("rol");
  ror_data_a:
    assert property (take && issueOp == OP_ROTATE_RIGHT_CARRY |=>
      regWrData == {$past(flagsIn[FLAG_C]), $past(issueRegData[7:1])})
    else $error("ror");
  io_write_a:
    assert property (tIo |=> !issueReady && !done ##1 done && ioWrEn
      && ioWrAddr == $past(issueIoAddr, 2) && flagsWrMask == MASK_NONE)
    else $error("io bit write");
  branch_time_a:
    assert property (tBr |=> ##[0:1] (done && flagsWrMask == MASK_NONE))
    else $error("branch timing");
  skip_time_a:
    assert property (tSkp |=> ##[0:2] (done && flagsWrMask == MASK_NONE
      && !ioWrEn)) else $error("skip timing");

  // Scenarios reached
  cover property (tCmp);
  cover property (tBr ##2 done);
  cover property (tIo ##2 ioWrEn);
endmodule

bind bsbse_exec bsbse_exec_props #(.PC_W(PC_W), .IO_W(IO_W)) props (
  .clk(clk), .reset_n(reset_n), .issueValid(issueValid),
  .issueReady(issueReady), .issueOp(issueOp), .issuePc(issuePc),
  .issueRegData(issueRegData), .issueIoAddr(issueIoAddr),
  .flagsIn(flagsIn), .done(done), .pcNext(pcNext), .regWrEn(regWrEn),
  .regWrData(regWrData), .flagsOut(flagsOut), .flagsWrMask(flagsWrMask),
  .ioWrEn(ioWrEn), .ioWrAddr(ioWrAddr)
);

// ==== verif/test_branch_skip_bit_shift_exec.sv ====
// Purpose: Self-checking bench.
// Assumes: Bench plays decoder, flags and I/O.
// Notes:   Ops are timed to their done pulse.
`timescale 1ns/1ps
module test_branch_skip_bit_shift_exec;
  import bsbse_pkg::*;
  localparam logic [15:0] PC0 = 16'h0100;
  localparam logic [5:0] IOA = 6'h2a;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic issueValid = 1'b0;
  bsbse_op_t issueOp = OP_NOP;
  logic [7:0] issueRegData = 8'h00;
  logic [7:0] issueImm = 8'h00;
  logic [2:0] issueBit = 3'h0;
  logic [2:0] issueFlagSel = 3'h0;
  logic [6:0] issueOffset = 7'h00;
  logic issueNextTwoWord = 1'b0;
  logic [7:0] flagsIn = 8'h00;
  logic issueReady, done, regWrEn, ioWrEn;
  logic [15:0] pcNext;
  logic [7:0] regWrData, flagsOut, flagsWrMask, ioWrData, ioRdData;
  logic [5:0] ioRdAddr, ioWrAddr;
  logic [7:0] ioMem [64];
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  bsbse_exec #(.PC_W(16), .OFS_W(7), .IO_W(6)) dut (
    .clk(clk), .reset_n(reset_n), .issueValid(issueValid),
    .issueReady(issueReady), .issueOp(issueOp), .issuePc(PC0),
    .issueRegData(issueRegData), .issueImm(issueImm),
    .issueBit(issueBit), .issueFlagSel(issueFlagSel),
    .issueOffset(issueOffset), .issueIoAddr(IOA),
    .issueNextTwoWord(issueNextTwoWord), .flagsIn(flagsIn), .done(done),
    .pcNext(pcNext), .regWrEn(regWrEn), .regWrData(regWrData),
    .flagsOut(flagsOut), .flagsWrMask(flagsWrMask), .ioRdAddr(ioRdAddr),
    .ioRdData(ioRdData), .ioWrEn(ioWrEn), .ioWrAddr(ioWrAddr),
    .ioWrData(ioWrData)
  );

  // I/O space model
  assign ioRdData = ioMem[ioRdAddr];
  always @(posedge clk) begin
    if (ioWrEn) ioMem[ioWrAddr] <= ioWrData;
  end

  // Hang guard; a run takes about 480 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Issue one op, count cycles up to done
  task automatic run(input bsbse_op_t op, input logic [7:0] rd, imm,
      input logic [2:0] b, input logic [6:0] k, input logic two,
      input logic [7:0] fl, output int n);
    @(posedge clk);
    issueOp <= op;
    issueRegData <= rd;
    issueImm <= imm;
    issueBit <= b;
    issueFlagSel <= b;
    issueOffset <= k;
    issueNextTwoWord <= two;
    flagsIn <= fl;
    issueValid <= 1'b1;
    @(posedge clk);
    issueValid <= 1'b0;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 5) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Reference branch condition, in op list order
  function automatic logic taken(bsbse_op_t op, logic [7:0] f,
      logic [2:0] s);
    int p = op - OP_BRANCH_IF_FLAG_SET;
    int sel [20] = '{0, 0, 1, 1, 0, 0, 0, 0, 2, 2, 8, 8, 5, 5, 6, 6, 3, 3,
      7, 7};
    logic [19:0] pol = 20'b0101_0101_1001_1001_0101;
    logic [8:0] v = {f[FLAG_N] ^ f[FLAG_V], f};
    return v[p < 2 ? s : sel[p]] == pol[p];
  endfunction

  // --------------------
  // Scenarios
  // --------------------
  task automatic tCompare();
    logic [7:0] v [4] = '{8'h10, 8'h05, 8'h80, 8'h7f};
    logic [7:0] a, b, d, f;
    int n;
    foreach (v[i]) begin
      foreach (v[j]) begin
        a = v[i];
        b = v[j];
        d = a - b;
        f = 8'hd0;
        f[FLAG_C] = a < b;
        f[FLAG_Z] = d == 8'h00;
        f[FLAG_N] = d[7];
        f[FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        f[FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
        run(OP_COMPARE_IMMEDIATE, a, b, 3'h0, 7'h00, 1'b0, 8'hd1, n);
        check("cmp cycles", 16'(n), 16'h1);
        check("cmp flags", flagsOut, f);
        check("cmp mask", flagsWrMask, MASK_CMP);
        check("cmp pc", pcNext, PC0 + 16'h1);
      end
    end
    $display("test compare finished");
  endtask

  task automatic tShift();
    logic [7:0] v [2] = '{8'h80, 8'h41};
    logic [7:0] r;
    logic c, co;
    int n;
    for (int i = 0; i < 8; i++) begin
      foreach (v[j]) begin
        c = i[0];
        case (i / 2)
          0: {co, r} = {v[j], 1'b0};
          1: {r, co} = {1'b0, v[j]};
          2: {co, r} = {v[j], c};
          default: {r, co} = {c, v[j]};
        endcase
        run(bsbse_op_t'(OP_SHIFT_LEFT_LOGICAL + i / 2), v[j], 8'h00, 3'h0,
          7'h00, 1'b0, {7'h78, c}, n);
        check("shift cycles", 16'(n), 16'h1);
        check("shift data", regWrData, r);
        check("shift flags", flagsOut,
          {4'hf, r[7] ^ co, r[7], r == 8'h00, co});
        check("shift wr", {regWrEn, flagsWrMask}, 9'h10f);
      end
    end
    $display("test shift finished");
  endtask

  task automatic tBranch();
    logic [7:0] fv [6] = '{8'h00, 8'hff, 8'h04, 8'h08, 8'h55, 8'haa};
    logic [6:0] k;
    logic [2:0] s;
    logic t;
    int n;
    for (int i = OP_BRANCH_IF_FLAG_SET; i <= OP_BRANCH_IF_IRQ_DISABLED;
        i++) begin
      foreach (fv[j]) begin
        k = j[0] ? 7'h7d : 7'h05;
        s = 3'(i * 3 + j);
        t = taken(bsbse_op_t'(i), fv[j], s);
        run(bsbse_op_t'(i), 8'h00, 8'h00, s, k, 1'b0, fv[j], n);
        check("br cycles", 16'(n), t ? 16'h2 : 16'h1);
        check("br pc", pcNext,
          PC0 + 16'h1 + (t ? {{9{k[6]}}, k} : 16'h0));
        check("br flags", flagsWrMask, MASK_NONE);
      end
    end
    $display("test branch finished");
  endtask

  task automatic tSkip();
    logic [7:0] pat = 8'ha5;
    logic [2:0] b;
    int n, len;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 8; j++) begin
        b = 3'(j * 3);
        len = (pat[b] == i[0]) ? 2 + j % 2 : 1;
        run(bsbse_op_t'(OP_SKIP_IF_REG_BIT_CLEAR + i),
          i < 2 ? pat : ~pat, 8'h00, b, 7'h00, j[0], 8'hff, n);
        check("skip cycles", 16'(n), 16'(len));
        check("skip pc", pcNext, PC0 + 16'(len));
        check("skip flags", flagsWrMask, MASK_NONE);
      end
    end
    $display("test skip finished");
  endtask

  // Chained edits of one I/O byte
  task automatic tIoBit();
    logic [7:0] cur;
    logic [2:0] b;
    int n;
    cur = ioMem[IOA];
    for (int j = 0; j < 4; j++) begin
      b = j[1] ? 3'h6 : 3'h1;
      cur = j[0] ? cur & ~(8'h01 << b) : cur | (8'h01 << b);
      run(j[0] ? OP_CLEAR_IO_BIT : OP_SET_IO_BIT, 8'h00, 8'h00, b, 7'h00,
        1'b0, 8'h00, n);
      check("io cycles", 16'(n), 16'h2);
      check("io wr", {ioWrEn, 2'b00, ioWrAddr}, {3'h4, IOA});
      check("io data", ioWrData, cur);
      check("io flags", flagsWrMask, MASK_NONE);
    end
    $display("test io bit finished");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Reset values, then each group
  initial begin
    for (int i = 0; i < 64; i++) ioMem[i] = 8'ha5;
    repeat (10) @(posedge clk);
    #1;
    check("reset ready", {issueReady, done, regWrEn, ioWrEn}, 4'h8);
    check("reset pc", pcNext, 16'h0000);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    tCompare();
    tShift();
    tBranch();
    tSkip();
    tIoBit();
    conclude();
  end
endmodule
